//--- rtl/gamma_dac_channel_otp_control.v
// Overview of operation
// - Each channel holds a 10-bit code; output equals supply times code over 1024.
// - In immediate mode a written code reaches its output right after the write, except when an update-all comes in the same cycle.
// - In deferred mode codes load silently, then all outputs update together.
// - General-call reset with programmed memory reloads channels from the last programmed values.
// - General-call reset with blank memory sets every channel to midsupply code.
// - Program command burns all eight channels, common-voltage included, at once.
// - Programmed values go into the bank chosen by the bank select input.
// - Write count of selected bank reads writes minus one, zero floor, max 15.
// - Bank select chooses bank 0 or bank 1 for programming and reload.
`timescale 1ns/1ps
`default_nettype none
`include "gamma_dac_defs.vh"

module gamma_dac_channel_otp_control #(
  parameter integer CHANNELS    = `GD_CHANNELS,
  parameter integer CODE_W      = `GD_CODE_W,
  parameter integer PROG_CYCLES = `GD_PROG_CYCLES
) (
  // Clock, reset and enable
  input  wire                     clk_i,
  input  wire                     rst_i,
  input  wire                     ce_i,
  // Channel write from the serial bus front end
  input  wire                     wr_i,
  input  wire [2:0]               wr_chan_i,
  input  wire [CODE_W-1:0]        wr_code_i,
  input  wire                     immediate_mode_i,
  input  wire                     update_all_i,
  // Commands
  input  wire                     gc_reset_i,
  input  wire                     prog_i,
  // Bank select pin, asynchronous
  input  wire                     nv_bank_select_i,
  // Readback
  input  wire [2:0]               rd_chan_i,
  output reg  [CODE_W-1:0]        rd_code_o,
  // Analog stage codes, flattened
  output reg  [CHANNELS*CODE_W-1:0] dac_code_o,
  // Status
  output reg                      busy_o,
  output reg  [`GD_CNT_W-1:0]     write_count_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_PROG = 1'b1;

  // Working codes as last written by the host, one word per channel.
  reg [CODE_W-1:0]      input_ff     [0:CHANNELS-1];
  // Nonvolatile image: bank 0 in the lower half, bank 1 in the upper half.
  reg [CODE_W-1:0]      nv_ff        [0:2*CHANNELS-1];
  // Programming history of each bank.
  reg [`GD_CNT_W-1:0]   cnt_ff       [0:1];
  reg                   used_ff      [0:1];
  // Bank select pin synchroniser and control state.
  reg [2:0]             bank_sync_ff;
  reg                   bank_ff;
  reg                   state_ff;
  reg                   prog_bank_ff;
  reg [15:0]            timer_ff;
  wire                  idle_w;
  wire                  prog_done_w;
  integer               i;

  // Count shows writes minus one, floored at zero, saturating at 15.
  function [`GD_CNT_W-1:0] shown_count;
    input                 used;
    input [`GD_CNT_W-1:0] cnt;
    begin
      shown_count = used ? cnt : `GD_CNT_RESET;
    end
  endfunction

  // Position of a channel inside the nonvolatile image of one bank.
  function integer nv_index;
    input         bank;
    input integer chan;
    begin
      nv_index = bank * CHANNELS + chan;
    end
  endfunction

  assign idle_w      = (state_ff == ST_IDLE);
  assign prog_done_w = (state_ff == ST_PROG) && (timer_ff <= 16'h0001);

  // The pin may move at any time, so three stages guard against metastability,
  // and the bank only switches once the two later stages agree.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bank_sync_ff <= 3'h0;
      bank_ff      <= 1'b0;
    end
    else if (ce_i)
    begin
      bank_sync_ff <= {bank_sync_ff[1:0], nv_bank_select_i};
      if (bank_sync_ff[2] == bank_sync_ff[1])
      begin
        bank_ff <= bank_sync_ff[2];
      end
    end
  end

  // Readback and count lag their sources by one cycle; the host must allow for it.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_code_o     <= `GD_CODE_RESET;
      write_count_o <= `GD_CNT_RESET;
    end
    else if (ce_i)
    begin
      rd_code_o     <= input_ff[rd_chan_i];
      write_count_o <= shown_count(used_ff[bank_ff], cnt_ff[bank_ff]);
    end
  end

  // The image and its counters change only at the end of a programming run.
  // Reset clears the image as well, since it is modelled by flip-flops.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (i = 0; i < 2; i = i + 1)
      begin
        cnt_ff[i]  <= `GD_CNT_RESET;
        used_ff[i] <= 1'b0;
      end
      for (i = 0; i < CHANNELS; i = i + 1)
      begin
        nv_ff[nv_index(1'b0, i)] <= `GD_CODE_RESET;
        nv_ff[nv_index(1'b1, i)] <= `GD_CODE_RESET;
      end
    end
    else if (ce_i && prog_done_w)
    begin
      for (i = 0; i < CHANNELS; i = i + 1)
      begin
        nv_ff[nv_index(prog_bank_ff, i)] <= input_ff[i];
      end
      if (used_ff[prog_bank_ff] && cnt_ff[prog_bank_ff] != `GD_CNT_MAX)
      begin
        cnt_ff[prog_bank_ff] <= cnt_ff[prog_bank_ff] + 4'h1;
      end
      used_ff[prog_bank_ff] <= 1'b1;
    end
  end

  // Programming takes a fixed time; writes and commands are dropped meanwhile, while readback keeps running.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff     <= ST_IDLE;
      prog_bank_ff <= 1'b0;
      timer_ff     <= 16'h0000;
      busy_o       <= 1'b0;
    end
    else if (ce_i)
    begin
      case (state_ff)
        ST_IDLE:
        begin
          // A general-call reset outranks a program command in the same cycle.
          if (prog_i && !gc_reset_i)
          begin
            state_ff     <= ST_PROG;
            busy_o       <= 1'b1;
            prog_bank_ff <= bank_ff;
            timer_ff     <= PROG_CYCLES[15:0];
          end
        end
        ST_PROG:
        begin
          if (prog_done_w)
          begin
            state_ff <= ST_IDLE;
            busy_o   <= 1'b0;
          end
          else
          begin
            timer_ff <= timer_ff - 16'h0001;
          end
        end
        default:
        begin
          state_ff <= ST_IDLE;
          busy_o   <= 1'b0;
        end
      endcase
    end
  end

  // Stored codes and output codes. After reset the outputs stay at zero until
  // the host updates them; an update-all then drives midsupply on any channel not yet written.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dac_code_o <= {CHANNELS*CODE_W{1'b0}};
      for (i = 0; i < CHANNELS; i = i + 1)
      begin
        input_ff[i] <= `GD_CODE_MID;
      end
    end
    else if (ce_i && idle_w)
    begin
      if (gc_reset_i)
      begin
        for (i = 0; i < CHANNELS; i = i + 1)
        begin
          if (used_ff[bank_ff])
          begin
            input_ff[i] <= nv_ff[nv_index(bank_ff, i)];
            dac_code_o[i*CODE_W +: CODE_W] <= nv_ff[nv_index(bank_ff, i)];
          end
          else
          begin
            input_ff[i] <= `GD_CODE_MID;
            dac_code_o[i*CODE_W +: CODE_W] <= `GD_CODE_MID;
          end
        end
      end
      else if (!prog_i)
      begin
        if (wr_i)
        begin
          input_ff[wr_chan_i] <= wr_code_i;
          if (immediate_mode_i)
          begin
            dac_code_o[wr_chan_i*CODE_W +: CODE_W] <= wr_code_i;
          end
        end
        if (update_all_i)
        begin
          for (i = 0; i < CHANNELS; i = i + 1)
          begin
            dac_code_o[i*CODE_W +: CODE_W] <= input_ff[i];
          end
        end
      end
    end
  end

endmodule // gamma_dac_channel_otp_control

`default_nettype wire

//--- rtl/gamma_dac_defs.vh
`ifndef GAMMA_DAC_DEFS_VH
`define GAMMA_DAC_DEFS_VH

`define GD_CHANNELS      8
`define GD_CODE_W        10
`define GD_CODE_MID      10'h200
`define GD_CODE_RESET    10'h000
`define GD_FULL_SCALE    1024
`define GD_CNT_W         4
`define GD_CNT_MAX       4'hF
`define GD_CNT_RESET     4'h0
`define GD_PROG_TIME_US  100
`define GD_CLK_MHZ       20
`define GD_PROG_CYCLES   (`GD_PROG_TIME_US * `GD_CLK_MHZ)

`endif

//--- test/gamma_dac_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gamma_dac_asserts (
  // Watched ports
  input wire clk_i, rst_i, ce_i, wr_i, immediate_mode_i, update_all_i, gc_reset_i, prog_i,
  input wire busy_o,
  input wire [2:0] wr_chan_i,
  input wire [9:0] wr_code_i,
  input wire [79:0] dac_code_o,
  input wire [3:0] write_count_o
);
  wire go = ce_i && !busy_o;
  // Blank memory is only certain until the first programming run.
  reg seen_ff;
  always @(posedge clk_i) seen_ff <= !rst_i && (seen_ff || busy_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr; wr_i && go && !gc_reset_i && !prog_i && !update_all_i; endsequence
  property p_imm; s_wr ##0 immediate_mode_i |=>
    dac_code_o[$past(wr_chan_i)*10+:10] == $past(wr_code_i); endproperty
  a_imm: assert property (p_imm) else $error("write missed output");
  property p_dfr; s_wr ##0 !immediate_mode_i |=> $stable(dac_code_o); endproperty
  a_dfr: assert property (p_dfr) else $error("deferred write moved output");
  property p_mid; go && gc_reset_i && !seen_ff |=> dac_code_o == {8{10'h200}}; endproperty
  a_mid: assert property (p_mid) else $error("blank reload not midsupply");
  property p_gc; go && gc_reset_i |=> !busy_o; endproperty
  a_gc: assert property (p_gc) else $error("reload started programming");
  property p_prg; go && prog_i && !gc_reset_i |=> busy_o [*2]; endproperty
  a_prg: assert property (p_prg) else $error("program not started");
  property p_len; $rose(busy_o) |-> busy_o [*3] ##[1:2] !busy_o; endproperty
  a_len: assert property (p_len) else $error("program length wrong");
  property p_frz; busy_o |=> $stable(dac_code_o); endproperty
  a_frz: assert property (p_frz) else $error("output moved while busy");
  property p_cnt; busy_o |=> $stable(write_count_o); endproperty
  a_cnt: assert property (p_cnt) else $error("count moved while busy");
endmodule // gamma_dac_asserts
bind gamma_dac_channel_otp_control gamma_dac_asserts u_chk (.*);
`default_nettype wire

//--- test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire clk_i,
  output logic wr_i, immediate_mode_i, update_all_i, gc_reset_i, prog_i,
  output logic [2:0] wr_chan_i, rd_chan_i,
  output logic [9:0] wr_code_i
);
  initial {wr_i, immediate_mode_i, update_all_i, gc_reset_i, prog_i} = 5'h0;
  initial {wr_chan_i, rd_chan_i, wr_code_i} = 16'h0;
  // Strobes last one cycle so that a rising edge never sees a write twice.
  task put(input logic m, input logic [2:0] c, input logic [9:0] d);
    @(negedge clk_i); {immediate_mode_i, wr_chan_i, rd_chan_i, wr_code_i} = {m, c, c, d};
    wr_i = 1'h1; @(negedge clk_i); wr_i = 1'h0;
  endtask
  task pulse(input logic [2:0] k);
    @(negedge clk_i); {prog_i, gc_reset_i, update_all_i} = k;
    @(negedge clk_i); {prog_i, gc_reset_i, update_all_i} = 3'h0;
  endtask
endmodule // host_model
`default_nettype wire

//--- test/tb_gamma_dac_channel_otp_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_gamma_dac_channel_otp_control;
  logic clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, nv_bank_select_i = 1'h0;
  wire wr_i, immediate_mode_i, update_all_i, gc_reset_i, prog_i, busy_o;
  wire [2:0] wr_chan_i, rd_chan_i;
  wire [9:0] wr_code_i, rd_code_o;
  wire [79:0] dac_code_o;
  wire [3:0] write_count_o;
  int num_errors = 0, n_compared = 0;
  logic [79:0] ex = {8{10'h200}};
  always #25 clk_i = ~clk_i;
  gamma_dac_channel_otp_control #(.PROG_CYCLES(4)) DUT (.*);
  host_model h (.*);
  task chk(input logic [79:0] g, e);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %0t got %h", $time, g);
    end
  endtask
  task close_out;
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task t_write;
    h.put(1'h1, 3'h6, 10'h044); ex[69:60] = 10'h044; chk(dac_code_o, ex);
    h.put(1'h0, 3'h7, 10'h3FF); chk(dac_code_o, ex);
    h.pulse(3'h1); ex[79:70] = 10'h3FF; chk(dac_code_o, ex);
  endtask
  // Writes issued while busy must be dropped.
  task t_prog;
    repeat (3)
    begin
      h.pulse(3'h4); h.put(1'h1, 3'h1, 10'h155); chk(dac_code_o, ex);
      repeat (6) @(negedge clk_i);
    end
    chk({76'h0, write_count_o}, 80'h2);
    h.put(1'h1, 3'h0, 10'h000); h.pulse(3'h2); chk(dac_code_o, ex);
    @(negedge clk_i);
    chk({70'h0, rd_code_o}, 80'h200);
  endtask
  // With the clock enable low a write must leave no trace.
  task t_hold;
    ex = {8{10'h200}}; ce_i = 1'h0;
    h.put(1'h1, 3'h2, 10'h123); chk(dac_code_o, ex);
    ce_i = 1'h1;
    h.put(1'h1, 3'h2, 10'h123); ex[29:20] = 10'h123; chk(dac_code_o, ex);
  endtask
  task t_bank;
    nv_bank_select_i = 1'h1; repeat (5) @(negedge clk_i);
    chk({76'h0, write_count_o}, 80'h0);
    h.pulse(3'h2); chk(dac_code_o, {8{10'h200}});
  endtask
  initial
  begin
    repeat (20) @(negedge clk_i);
    rst_i = 1'h0; h.pulse(3'h2); chk(dac_code_o, ex);
    t_write; t_prog; t_bank; t_hold; close_out;
  end
  initial
  begin
    #20000 num_errors++;
    close_out;
  end
endmodule // tb_gamma_dac_channel_otp_control
`default_nettype wire
